//--- rtl/urbb_defines.svh
// Constants of the UART/radio bridge buffer
`ifndef URBB_DEFINES_SVH
`define URBB_DEFINES_SVH
`define URBB_CLK_HZ        125000000
`define URBB_BAUD          19200
`define URBB_BITS_PER_CHAR 10
`define URBB_GAP_CHARS     3
`define URBB_LBT_LISTEN_MS 5
`define URBB_BACKOFF_MS    1
`define URBB_EMIT_UNIT_MS  10
`define URBB_CRC_CYC       5'h10
`define URBB_RXB_DEPTH     512
`define URBB_EMB_DEPTH     256
`define URBB_STAGE_DEPTH   8
`define URBB_ADDR_DLY_LO   8'h12
`define URBB_ADDR_DLY_HI   8'h13
`define URBB_ADDR_MODE     8'h14
`define URBB_ADDR_OPT      8'h4F
`define URBB_RST_DLY       8'h00
`define URBB_RST_MODE      8'h03
`define URBB_RST_OPT       8'h00
`define URBB_MODE_ALL      0
`define URBB_MODE_TXPKT    1
`define URBB_MODE_RXPKT    2
`define URBB_OPT_CRC       3
`define URBB_OPT_LBT       4
`define URBB_OPT_LDRO      7
`endif

//--- rtl/urbb_fifo.sv
// Parameterised valid/ready FIFO
`timescale 1ns/10ps
module urbb_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 8
) (
  input  wire logic         clk_in,
  input  wire logic         arst_n_in,
  input  wire logic         in_valid_in,
  output logic              in_ready_out,
  input  wire logic [W-1:0] in_data_in,
  output logic              out_valid_out,
  input  wire logic         out_ready_in,
  output logic [W-1:0]      out_data_out
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [0:DEPTH-1];
  logic [AW:0]  wp;
  logic [AW:0]  rp;
  logic         full;
  logic         empty;

  // Full when pointers differ only in wrap bit
  assign full          = (wp[AW-1:0] == rp[AW-1:0]) && (wp[AW] != rp[AW]);
  assign empty         = (wp == rp);
  assign in_ready_out  = !full;
  assign out_valid_out = !empty;
  assign out_data_out  = mem[rp[AW-1:0]];

  // Storage write
  always_ff @(posedge clk_in) begin
    if (in_valid_in && !full) begin
      mem[wp[AW-1:0]] <= in_data_in;
    end
  end

  // Pointers
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      wp <= '0;
      rp <= '0;
    end else begin
      if (in_valid_in && !full) begin
        wp <= wp + 1'b1;
      end
      if (out_ready_in && !empty) begin
        rp <= rp + 1'b1;
      end
    end
  end
endmodule : urbb_fifo

//--- rtl/urbb_pkg.sv
// Types of the UART/radio bridge buffer
package urbb_pkg;
  typedef enum logic [3:0] {
    URBB_TX_IDLE    = 4'h1,
    URBB_TX_LISTEN  = 4'h2,
    URBB_TX_BACKOFF = 4'h4,
    URBB_TX_SEND    = 4'h8
  } urbb_txst_e;
endpackage : urbb_pkg

//--- rtl/urbb_top.sv
// UART to radio bridge: buffers, framing, pacing
`timescale 1ns/10ps
`include "urbb_defines.svh"
module urbb_top #(
  parameter int BIT_CYC       = `URBB_CLK_HZ / `URBB_BAUD,
  parameter int GAP_CYC       = `URBB_GAP_CHARS * `URBB_BITS_PER_CHAR * (`URBB_CLK_HZ / `URBB_BAUD),
  parameter int LISTEN_CYC    = `URBB_LBT_LISTEN_MS * (`URBB_CLK_HZ / 1000),
  parameter int BACKOFF_CYC   = `URBB_BACKOFF_MS * (`URBB_CLK_HZ / 1000),
  parameter int EMIT_UNIT_CYC = `URBB_EMIT_UNIT_MS * (`URBB_CLK_HZ / 1000)
) (
  input  wire logic        SYS_CLK_IN,
  input  wire logic        ARST_N_IN,
  input  wire logic        UART_RXD_IN,
  output logic             UART_TXD_OUT,
  input  wire logic        REG_WR_IN,
  input  wire logic [7:0]  REG_ADDR_IN,
  input  wire logic [7:0]  REG_WDATA_IN,
  output logic [7:0]       REG_RDATA_OUT,
  input  wire logic [3:0]  CFG_SF_IN,
  input  wire logic [2:0]  CFG_CR_IN,
  input  wire logic [9:0]  CFG_BW_KHZ_IN,
  output logic             RF_TX_VALID_OUT,
  output logic [7:0]       RF_TX_DATA_OUT,
  output logic             RF_TX_LAST_OUT,
  output logic [2:0]       RF_TX_CR_OUT,
  input  wire logic        RF_TX_READY_IN,
  output logic             RF_TX_ACTIVE_OUT,
  input  wire logic        RF_CHAN_BUSY_IN,
  input  wire logic        RF_RX_VALID_IN,
  input  wire logic [7:0]  RF_RX_DATA_IN,
  input  wire logic        RF_RX_LAST_IN,
  input  wire logic        RF_RX_ADDR_OK_IN,
  output logic             LOW_RATE_OPT_OUT,
  output logic             CRC_EN_OUT,
  output logic [19:0]      SYMBOL_RATE_OUT,
  output logic [23:0]      DATA_RATE_OUT,
  output logic             RX_OVERFLOW_OUT,
  output logic             EMIT_OVERFLOW_OUT
);
  import urbb_pkg::*;

  logic [7:0]  dly_lo;
  logic [7:0]  dly_hi;
  logic [7:0]  mode;
  logic [7:0]  opt;
  logic        pkt_tx;
  logic        rx_valid;
  logic [7:0]  rx_data;
  logic [7:0]  rxb_mem [0:`URBB_RXB_DEPTH-1];
  logic [9:0]  rxb_wp;
  logic [9:0]  rxb_rp;
  logic        rxb_full;
  logic        rxb_empty;
  logic        rxb_push;
  logic [9:0]  frq_mem [0:7];
  logic [3:0]  frq_wp;
  logic [3:0]  frq_rp;
  logic        frq_empty;
  logic        frq_full;
  logic        frame_open;
  logic [23:0] gap_cnt;
  logic        frame_avail;
  logic [9:0]  send_end;
  logic        send_move;
  logic        stg_ready;
  urbb_txst_e  txst;
  logic [23:0] lbt_cnt;
  logic [7:0]  lfsr;
  logic [23:0] rnd_wait;
  logic        rf_rx_busy;
  logic        rf_take;
  logic        em_in_ready;
  logic        em_valid;
  logic [7:0]  em_data;
  logic        em_pop;
  logic        frame_done;
  logic        em_trig;
  logic        em_wait;
  logic        em_open;
  logic [15:0] em_ticks;
  logic [23:0] em_unit;
  logic [4:0]  em_crc;
  logic        utx_ready;
  logic [31:0] bw_hz;
  logic [31:0] sym_rate;
  logic [31:0] dat_rate;

  // Register writes
  always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      dly_lo <= `URBB_RST_DLY;
      dly_hi <= `URBB_RST_DLY;
      mode   <= `URBB_RST_MODE;
      opt    <= `URBB_RST_OPT;
    end else if (REG_WR_IN) begin
      unique case (REG_ADDR_IN)
        `URBB_ADDR_DLY_LO: dly_lo <= REG_WDATA_IN;
        `URBB_ADDR_DLY_HI: dly_hi <= REG_WDATA_IN;
        `URBB_ADDR_MODE:   mode   <= REG_WDATA_IN;
        `URBB_ADDR_OPT:    opt    <= REG_WDATA_IN;
        default: ;
      endcase
    end
  end

  // Register reads, unmapped reads zero
  always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      REG_RDATA_OUT <= 8'h00;
    end else begin
      unique case (REG_ADDR_IN)
        `URBB_ADDR_DLY_LO: REG_RDATA_OUT <= dly_lo;
        `URBB_ADDR_DLY_HI: REG_RDATA_OUT <= dly_hi;
        `URBB_ADDR_MODE:   REG_RDATA_OUT <= mode;
        `URBB_ADDR_OPT:    REG_RDATA_OUT <= opt;
        default:           REG_RDATA_OUT <= 8'h00;
      endcase
    end
  end

  assign pkt_tx           = mode[`URBB_MODE_TXPKT];
  assign LOW_RATE_OPT_OUT = !opt[`URBB_OPT_LDRO];
  assign CRC_EN_OUT       = opt[`URBB_OPT_CRC];

  // Serial line to and from the host
  urbb_uart #(.BIT_CYC(BIT_CYC)) u_uart (
    .clk_in       (SYS_CLK_IN),
    .arst_n_in    (ARST_N_IN),
    .rxd_in       (UART_RXD_IN),
    .rx_valid_out (rx_valid),
    .rx_data_out  (rx_data),
    .tx_valid_in  (em_open && em_valid),
    .tx_ready_out (utx_ready),
    .tx_data_in   (em_data),
    .txd_out      (UART_TXD_OUT)
  );

  // Receive ring of 512 bytes
  assign rxb_full  = (rxb_wp[8:0] == rxb_rp[8:0]) && (rxb_wp[9] != rxb_rp[9]);
  assign rxb_empty = (rxb_wp == rxb_rp);
  assign rxb_push  = rx_valid && !rxb_full;

  always_ff @(posedge SYS_CLK_IN) begin
    if (rxb_push) begin
      rxb_mem[rxb_wp[8:0]] <= rx_data;
    end
  end

  // Ring pointers
  always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      rxb_wp <= 10'h000;
      rxb_rp <= 10'h000;
    end else begin
      if (rxb_push) begin
        rxb_wp <= rxb_wp + 10'h001;
      end
      if (send_move) begin
        rxb_rp <= rxb_rp + 10'h001;
      end
    end
  end

  // Receive overflow: set wins over drain clear
  always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      RX_OVERFLOW_OUT <= 1'b0;
    end else if (rx_valid && rxb_full) begin
      RX_OVERFLOW_OUT <= 1'b1;
    end else if (rxb_empty) begin
      RX_OVERFLOW_OUT <= 1'b0;
    end
  end

  // Idle-gap timer closes a frame after three characters of silence
  assign frq_empty = (frq_wp == frq_rp);
  assign frq_full  = (frq_wp[2:0] == frq_rp[2:0]) && (frq_wp[3] != frq_rp[3]);

  always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      frame_open <= 1'b0;
      gap_cnt    <= 24'h000000;
      frq_wp     <= 4'h0;
    end else if (rxb_push) begin
      frame_open <= pkt_tx;
      gap_cnt    <= 24'(GAP_CYC - 1);
    end else if (frame_open && !rx_valid) begin
      if (gap_cnt != 24'h000000) begin
        gap_cnt <= gap_cnt - 24'h000001;
      end else if (!frq_full) begin
        frq_mem[frq_wp[2:0]] <= rxb_wp;
        frq_wp               <= frq_wp + 4'h1;
        frame_open           <= 1'b0;
      end
    end
  end

  // Frame available: closed frame in packet mode, any byte otherwise
  assign frame_avail = pkt_tx ? !frq_empty : !rxb_empty;
  assign send_end    = pkt_tx ? frq_mem[frq_rp[2:0]] : rxb_wp;
  assign send_move   = (txst == URBB_TX_SEND) && stg_ready && (rxb_rp != send_end);
  assign rnd_wait    = 24'(((32'(lfsr[2:0]) % 5) + 1) * BACKOFF_CYC);

  // Radio emission sequencer
  always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      txst         <= URBB_TX_IDLE;
      lbt_cnt      <= 24'h000000;
      frq_rp       <= 4'h0;
      RF_TX_CR_OUT <= 3'h0;
    end else begin
      unique case (txst)
        URBB_TX_IDLE: begin
          if (frame_avail && !rf_rx_busy && !rf_take && !RF_TX_VALID_OUT) begin
            RF_TX_CR_OUT <= CFG_CR_IN;
            if (opt[`URBB_OPT_LBT]) begin
              txst    <= URBB_TX_LISTEN;
              lbt_cnt <= 24'(LISTEN_CYC - 1);
            end else begin
              txst <= URBB_TX_SEND;
            end
          end
        end
        URBB_TX_LISTEN: begin
          if (RF_CHAN_BUSY_IN) begin
            txst    <= URBB_TX_BACKOFF;
            lbt_cnt <= rnd_wait;
          end else if (lbt_cnt == 24'h000000) begin
            txst <= URBB_TX_SEND;
          end else begin
            lbt_cnt <= lbt_cnt - 24'h000001;
          end
        end
        URBB_TX_BACKOFF: begin
          if (RF_CHAN_BUSY_IN) begin
            lbt_cnt <= rnd_wait;
          end else if (lbt_cnt == 24'h000000) begin
            txst <= URBB_TX_SEND;
          end else begin
            lbt_cnt <= lbt_cnt - 24'h000001;
          end
        end
        URBB_TX_SEND: begin
          if (rxb_rp == send_end) begin
            txst <= URBB_TX_IDLE;
            if (pkt_tx) begin
              frq_rp <= frq_rp + 4'h1;
            end
          end
        end
        default: txst <= URBB_TX_IDLE;
      endcase
    end
  end

  // Pseudo-random source for the back-off
  always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      lfsr <= 8'hA5;
    end else begin
      lfsr <= {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
    end
  end

  // Eight-word stage toward the radio, last flag in bit 8
  urbb_fifo #(.W(9), .DEPTH(`URBB_STAGE_DEPTH)) u_stage (
    .clk_in        (SYS_CLK_IN),
    .arst_n_in     (ARST_N_IN),
    .in_valid_in   (send_move),
    .in_ready_out  (stg_ready),
    .in_data_in    ({(rxb_rp + 10'h001) == send_end, rxb_mem[rxb_rp[8:0]]}),
    .out_valid_out (RF_TX_VALID_OUT),
    .out_ready_in  (RF_TX_READY_IN),
    .out_data_out  ({RF_TX_LAST_OUT, RF_TX_DATA_OUT})
  );

  assign RF_TX_ACTIVE_OUT = (txst == URBB_TX_SEND) || RF_TX_VALID_OUT;

  // Radio reception accepted only while not emitting
  assign rf_take = RF_RX_VALID_IN && (txst == URBB_TX_IDLE) && !RF_TX_VALID_OUT
                   && (mode[`URBB_MODE_ALL] || RF_RX_ADDR_OK_IN);

  // Radio frame in progress blocks emission start
  always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      rf_rx_busy <= 1'b0;
    end else if (rf_take) begin
      rf_rx_busy <= !RF_RX_LAST_IN;
    end
  end

  // Emission ring of 256 bytes
  urbb_fifo #(.W(8), .DEPTH(`URBB_EMB_DEPTH)) u_emit (
    .clk_in        (SYS_CLK_IN),
    .arst_n_in     (ARST_N_IN),
    .in_valid_in   (rf_take),
    .in_ready_out  (em_in_ready),
    .in_data_in    (RF_RX_DATA_IN),
    .out_valid_out (em_valid),
    .out_ready_in  (em_pop),
    .out_data_out  (em_data)
  );

  assign em_pop = em_open && utx_ready;

  // Emission overflow and completed-frame flags; set wins
  always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      EMIT_OVERFLOW_OUT <= 1'b0;
      frame_done        <= 1'b0;
    end else begin
      if (rf_take && !em_in_ready) begin
        EMIT_OVERFLOW_OUT <= 1'b1;
      end else if (!em_valid) begin
        EMIT_OVERFLOW_OUT <= 1'b0;
      end
      if (rf_take && RF_RX_LAST_IN) begin
        frame_done <= 1'b1;
      end else if (!em_valid) begin
        frame_done <= 1'b0;
      end
    end
  end

  assign em_trig = mode[`URBB_MODE_RXPKT] ? frame_done : em_valid;

  // Serial emission delay: n x 10 ms, then CRC time, then drain
  always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      em_wait  <= 1'b0;
      em_open  <= 1'b0;
      em_ticks <= 16'h0000;
      em_unit  <= 24'h000000;
      em_crc   <= 5'h00;
    end else if (!em_wait && !em_open) begin
      if (em_trig) begin
        em_wait  <= 1'b1;
        em_ticks <= {dly_hi, dly_lo};
        em_unit  <= 24'(EMIT_UNIT_CYC - 1);
        em_crc   <= opt[`URBB_OPT_CRC] ? `URBB_CRC_CYC : 5'h00;
      end
    end else if (em_wait) begin
      if (em_ticks != 16'h0000) begin
        if (em_unit == 24'h000000) begin
          em_unit  <= 24'(EMIT_UNIT_CYC - 1);
          em_ticks <= em_ticks - 16'h0001;
        end else begin
          em_unit <= em_unit - 24'h000001;
        end
      end else if (em_crc != 5'h00) begin
        em_crc <= em_crc - 5'h01;
      end else begin
        em_wait <= 1'b0;
        em_open <= 1'b1;
      end
    end else if (!em_valid) begin
      em_open <= 1'b0;
    end
  end

  // Radio rate figures from bandwidth, SF and CR
  assign bw_hz    = 32'(CFG_BW_KHZ_IN) * 32'h0000_03E8;
  assign sym_rate = bw_hz >> CFG_SF_IN;
  assign dat_rate = (32'(CFG_SF_IN) * sym_rate * 32'h0000_0004) / (32'h0000_0004 + 32'(CFG_CR_IN));

  always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      SYMBOL_RATE_OUT <= 20'h00000;
      DATA_RATE_OUT   <= 24'h000000;
    end else begin
      SYMBOL_RATE_OUT <= sym_rate[19:0];
      DATA_RATE_OUT   <= dat_rate[23:0];
    end
  end
endmodule : urbb_top

//--- rtl/urbb_uart.sv
// 8N1 serial receiver and transmitter
`timescale 1ns/10ps
module urbb_uart #(
  parameter int BIT_CYC = 6510
) (
  input  wire logic       clk_in,
  input  wire logic       arst_n_in,
  input  wire logic       rxd_in,
  output logic            rx_valid_out,
  output logic [7:0]      rx_data_out,
  input  wire logic       tx_valid_in,
  output logic            tx_ready_out,
  input  wire logic [7:0] tx_data_in,
  output logic            txd_out
);
  logic [1:0]  rx_sync;
  logic        rxd;
  logic        rx_act;
  logic [15:0] rx_cnt;
  logic [3:0]  rx_bit;
  logic [7:0]  rx_sh;
  logic        tx_act;
  logic [15:0] tx_cnt;
  logic [3:0]  tx_bit;
  logic [9:0]  tx_sh;

  assign rxd          = rx_sync[1];
  assign tx_ready_out = !tx_act;
  assign txd_out      = tx_sh[0];

  // Two-stage synchroniser on the line
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rx_sync <= 2'h3;
    end else begin
      rx_sync <= {rx_sync[0], rxd_in};
    end
  end

  // Receiver samples at bit centres
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rx_act       <= 1'b0;
      rx_cnt       <= 16'h0000;
      rx_bit       <= 4'h0;
      rx_sh        <= 8'h00;
      rx_valid_out <= 1'b0;
      rx_data_out  <= 8'h00;
    end else begin
      rx_valid_out <= 1'b0;
      if (!rx_act) begin
        if (!rxd) begin
          rx_act <= 1'b1;
          rx_cnt <= 16'(BIT_CYC / 2);
          rx_bit <= 4'h0;
        end
      end else if (rx_cnt != 16'h0000) begin
        rx_cnt <= rx_cnt - 16'h0001;
      end else begin
        rx_cnt <= 16'(BIT_CYC - 1);
        rx_bit <= rx_bit + 4'h1;
        if (rx_bit == 4'h0) begin
          if (rxd) begin
            rx_act <= 1'b0;  // False start
          end
        end else if (rx_bit <= 4'h8) begin
          rx_sh <= {rxd, rx_sh[7:1]};
        end else begin
          rx_act <= 1'b0;
          if (rxd) begin
            rx_valid_out <= 1'b1;
            rx_data_out  <= rx_sh;
          end
        end
      end
    end
  end

  // Transmitter: start, 8 data, stop
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      tx_act <= 1'b0;
      tx_cnt <= 16'h0000;
      tx_bit <= 4'h0;
      tx_sh  <= 10'h3FF;
    end else if (!tx_act) begin
      if (tx_valid_in) begin
        tx_sh  <= {1'b1, tx_data_in, 1'b0};
        tx_act <= 1'b1;
        tx_cnt <= 16'(BIT_CYC - 1);
        tx_bit <= 4'h0;
      end
    end else if (tx_cnt != 16'h0000) begin
      tx_cnt <= tx_cnt - 16'h0001;
    end else begin
      tx_sh  <= {1'b1, tx_sh[9:1]};
      tx_cnt <= 16'(BIT_CYC - 1);
      tx_bit <= tx_bit + 4'h1;
      if (tx_bit == 4'h9) begin
        tx_act <= 1'b0;
      end
    end
  end
endmodule : urbb_uart

//--- test/urbb_host.sv
// Host controller model on the serial link
`timescale 1ns/10ps
module urbb_host #(
  parameter int BIT_CYC = 8
) (
  input  wire logic clk_in,
  output logic      txd_out,
  input  wire logic rxd_in
);
  logic [7:0] rx_q[$];
  logic [7:0] rx_byte;
  // Line idles high
  initial txd_out = 1'b1;
  // One 8N1 character at the bridge rate
  task automatic send_byte(input logic [7:0] b);
    logic [9:0] frame;
    frame = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(negedge clk_in);
      txd_out = frame[i];
      repeat (BIT_CYC - 1) @(negedge clk_in);
    end
  endtask : send_byte
  // Sample returning characters mid-bit
  always begin
    @(negedge rxd_in);
    repeat (BIT_CYC + BIT_CYC / 2) @(posedge clk_in);
    for (int i = 0; i < 8; i++) begin
      rx_byte[i] = rxd_in;
      repeat (BIT_CYC) @(posedge clk_in);
    end
    rx_q.push_back(rx_byte);
  end
endmodule : urbb_host

//--- test/urbb_props.sv
// Port checker for the bridge top
`timescale 1ns/10ps
module urbb_props (
  input wire logic        SYS_CLK_IN, ARST_N_IN, REG_WR_IN,
  input wire logic [7:0]  REG_ADDR_IN, REG_WDATA_IN, REG_RDATA_OUT,
  input wire logic [3:0]  CFG_SF_IN,
  input wire logic [9:0]  CFG_BW_KHZ_IN,
  input wire logic        RF_TX_VALID_OUT, RF_TX_LAST_OUT, RF_TX_READY_IN, RF_TX_ACTIVE_OUT,
  input wire logic [7:0]  RF_TX_DATA_OUT,
  input wire logic [2:0]  RF_TX_CR_OUT,
  input wire logic        LOW_RATE_OPT_OUT, CRC_EN_OUT,
  input wire logic [19:0] SYMBOL_RATE_OUT
);
  default clocking dc @(posedge SYS_CLK_IN); endclocking
  default disable iff (!ARST_N_IN);
  // Mode write followed by a read of the same place
  sequence s_mode_wr; REG_WR_IN && REG_ADDR_IN == 8'h14; endsequence
  sequence s_mode_rd; !REG_WR_IN && REG_ADDR_IN == 8'h14; endsequence
  sequence s_stalled; RF_TX_VALID_OUT && !RF_TX_READY_IN; endsequence
  chk_mode_readback: assert property (s_mode_wr ##1 s_mode_rd |=> REG_RDATA_OUT == $past(REG_WDATA_IN, 2))
    else $error("mode readback wrong");
  chk_unmapped_zero: assert property (!(REG_ADDR_IN inside {8'h12, 8'h13, 8'h14, 8'h4F}) |=> REG_RDATA_OUT == 8'h00)
    else $error("unmapped read not zero");
  chk_ldro_polarity: assert property (REG_WR_IN && REG_ADDR_IN == 8'h4F |=> LOW_RATE_OPT_OUT != $past(REG_WDATA_IN[7]))
    else $error("optimizer polarity wrong");
  chk_crc_enable: assert property (REG_WR_IN && REG_ADDR_IN == 8'h4F |=> CRC_EN_OUT == $past(REG_WDATA_IN[3]))
    else $error("crc enable wrong");
  chk_byte_stands: assert property (s_stalled |=> RF_TX_VALID_OUT && $stable(RF_TX_DATA_OUT) && $stable(RF_TX_LAST_OUT))
    else $error("radio byte dropped while stalled");
  chk_cr_held: assert property (s_stalled |=> $stable(RF_TX_CR_OUT))
    else $error("coding rate moved in frame");
  chk_half_duplex: assert property (RF_TX_VALID_OUT |-> RF_TX_ACTIVE_OUT)
    else $error("byte offered while not emitting");
  chk_symbol_rate: assert property ($past(ARST_N_IN) && $stable(CFG_BW_KHZ_IN) && $stable(CFG_SF_IN)
    |-> SYMBOL_RATE_OUT == 20'((32'(CFG_BW_KHZ_IN) * 1000) >> CFG_SF_IN)) else $error("symbol rate wrong");
endmodule : urbb_props
bind urbb_top urbb_props i_props (.SYS_CLK_IN(SYS_CLK_IN), .ARST_N_IN(ARST_N_IN), .REG_WR_IN(REG_WR_IN),
  .REG_ADDR_IN(REG_ADDR_IN), .REG_WDATA_IN(REG_WDATA_IN), .REG_RDATA_OUT(REG_RDATA_OUT), .CFG_SF_IN(CFG_SF_IN),
  .CFG_BW_KHZ_IN(CFG_BW_KHZ_IN), .RF_TX_VALID_OUT(RF_TX_VALID_OUT), .RF_TX_LAST_OUT(RF_TX_LAST_OUT),
  .RF_TX_READY_IN(RF_TX_READY_IN), .RF_TX_ACTIVE_OUT(RF_TX_ACTIVE_OUT), .RF_TX_DATA_OUT(RF_TX_DATA_OUT),
  .RF_TX_CR_OUT(RF_TX_CR_OUT), .LOW_RATE_OPT_OUT(LOW_RATE_OPT_OUT), .CRC_EN_OUT(CRC_EN_OUT),
  .SYMBOL_RATE_OUT(SYMBOL_RATE_OUT));

//--- test/urbb_top_test.sv
// Self-checking bench of the bridge top
`timescale 1ns/10ps
module urbb_top_test;
  localparam int BIT_CYC = 8;
  localparam int GAP_CYC = 240;
  localparam int LISTEN_CYC = 50;
  localparam int BACKOFF_CYC = 10;
  localparam int EMIT_UNIT_CYC = 20;
  logic        clk, arst_n, reg_wr, rf_ready, rf_rx_valid, rf_rx_last, rxd, txd, hold, chan_busy, addr_ok;
  logic [3:0]  sf;
  logic [9:0]  bw;
  logic [7:0]  reg_addr, reg_wdata, rdata, rf_rx_data, tx_data;
  logic [2:0]  cfg_cr, tx_cr;
  logic        tx_valid, tx_last, tx_active, ldro, crc_en, rx_ovf, em_ovf;
  logic [19:0] sym;
  logic [23:0] drate;
  logic [11:0] mon_q[$];
  logic [7:0]  pk[3] = '{8'h11, 8'h22, 8'h33};
  int          err_total, comparisons;

  urbb_top #(.BIT_CYC(BIT_CYC), .GAP_CYC(GAP_CYC), .LISTEN_CYC(LISTEN_CYC), .BACKOFF_CYC(BACKOFF_CYC),
    .EMIT_UNIT_CYC(EMIT_UNIT_CYC)) i_dut (
    .SYS_CLK_IN(clk), .ARST_N_IN(arst_n), .UART_RXD_IN(rxd), .UART_TXD_OUT(txd), .REG_WR_IN(reg_wr),
    .REG_ADDR_IN(reg_addr), .REG_WDATA_IN(reg_wdata), .REG_RDATA_OUT(rdata), .CFG_SF_IN(sf),
    .CFG_CR_IN(cfg_cr), .CFG_BW_KHZ_IN(bw), .RF_TX_VALID_OUT(tx_valid), .RF_TX_DATA_OUT(tx_data),
    .RF_TX_LAST_OUT(tx_last), .RF_TX_CR_OUT(tx_cr), .RF_TX_READY_IN(rf_ready), .RF_TX_ACTIVE_OUT(tx_active),
    .RF_CHAN_BUSY_IN(chan_busy), .RF_RX_VALID_IN(rf_rx_valid), .RF_RX_DATA_IN(rf_rx_data),
    .RF_RX_LAST_IN(rf_rx_last),
    .RF_RX_ADDR_OK_IN(addr_ok), .LOW_RATE_OPT_OUT(ldro), .CRC_EN_OUT(crc_en), .SYMBOL_RATE_OUT(sym),
    .DATA_RATE_OUT(drate), .RX_OVERFLOW_OUT(rx_ovf), .EMIT_OVERFLOW_OUT(em_ovf));
  urbb_host #(.BIT_CYC(BIT_CYC)) i_host (.clk_in(clk), .txd_out(rxd), .rxd_in(txd));

  // Clock
  initial clk = 1'b0;
  always #4 clk = ~clk;
  // Record every byte taken by the radio
  always @(posedge clk) if (tx_valid && rf_ready) mon_q.push_back({tx_cr, tx_last, tx_data});

  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %0t got %h want %h", $time, seen, exp);
    end
  endtask : check
  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask : reg_write
  task automatic reg_chk(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk);
    reg_addr = a;
    @(negedge clk);
    check(rdata, exp);
  endtask : reg_chk
  task automatic rf_byte(input logic [7:0] d, input logic l);
    @(negedge clk);
    rf_rx_data = d;
    rf_rx_last = l;
    rf_rx_valid = 1'b1;
    @(negedge clk);
    rf_rx_valid = 1'b0;
  endtask : rf_byte
  task automatic close_out();
    if (err_total == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : close_out

  // Watchdog
  initial begin
    repeat (60000) @(posedge clk);
    err_total++;
    close_out();
  end

  initial begin
    {arst_n, reg_wr, reg_addr, reg_wdata, rf_rx_valid, rf_rx_last, rf_rx_data} = '0;
    {rf_ready, cfg_cr, err_total, comparisons} = {1'b1, 3'h1, 64'h0};
    {sf, bw, chan_busy, addr_ok} = {4'h7, 10'h07D, 2'h0};
    repeat (6) @(negedge clk);
    arst_n = 1'b1;
    repeat (4) @(negedge clk);
    // Reset values, option write, unmapped place
    reg_chk(8'h12, 8'h00);
    reg_chk(8'h13, 8'h00);
    reg_chk(8'h14, 8'h03);
    check(ldro, 1'b1);
    // Rate figures at 125 kHz, SF 7 then SF 12
    check(sym, 24'h0003D0);
    check(drate, 24'h001559);
    sf = 4'hC;
    repeat (2) @(negedge clk);
    check(sym, 24'h00001E);
    check(drate, 24'h000120);
    check(ldro, 1'b1);
    reg_write(8'h4F, 8'h88);
    reg_chk(8'h4F, 8'h88);
    check({ldro, crc_en}, 2'h1);
    reg_write(8'h4F, 8'h00);
    reg_write(8'h30, 8'hFF);
    reg_chk(8'h30, 8'h00);
    // Endless mode: byte goes out without a gap
    reg_write(8'h14, 8'h01);
    i_host.send_byte(8'h3C);
    repeat (20) @(negedge clk);
    check(12'(mon_q.size()), 12'h001);
    check(mon_q.pop_front() & 12'h0FF, 12'h03C);
    // Listen before talk: quiet listen, then busy back-off
    reg_write(8'h4F, 8'h10);
    i_host.send_byte(8'h4B);
    repeat (30) @(negedge clk);
    check(24'(mon_q.size()), 24'h000000);
    repeat (40) @(negedge clk);
    check(24'(mon_q.size()), 24'h000001);
    chan_busy = 1'b1;
    i_host.send_byte(8'hB4);
    repeat (100) @(negedge clk);
    check(24'(mon_q.size()), 24'h000001);
    chan_busy = 1'b0;
    repeat (70) @(negedge clk);
    check(24'(mon_q.size()), 24'h000002);
    mon_q.delete();
    reg_write(8'h4F, 8'h00);
    // Packet mode: frame released after the idle gap
    reg_write(8'h14, 8'h03);
    cfg_cr = 3'h3;
    foreach (pk[i]) i_host.send_byte(pk[i]);
    repeat (GAP_CYC - 40) @(negedge clk);
    check(12'(mon_q.size()), 12'h000);
    repeat (60) @(negedge clk);
    for (int i = 0; i < 3; i++)
      check(mon_q.pop_front(), {3'h3, i == 2, pk[i]});
    // Foreign radio byte dropped while all-traffic is off
    reg_write(8'h14, 8'h02);
    rf_byte(8'hE1, 1'b1);
    reg_write(8'h14, 8'h03);
    // Radio bytes return after a two-unit delay
    reg_write(8'h12, 8'h02);
    rf_byte(8'h5A, 1'b0);
    rf_byte(8'h96, 1'b1);
    hold = 1'b1;
    repeat (35) begin
      @(negedge clk);
      if (txd !== 1'b1) hold = 1'b0;
    end
    check(hold, 1'b1);
    repeat (300) @(negedge clk);
    check(12'(i_host.rx_q.size()), 12'h002);
    check(i_host.rx_q.pop_front(), 8'h5A);
    check(i_host.rx_q.pop_front(), 8'h96);
    // Long delay, then one radio byte more than the emission ring holds
    reg_write(8'h13, 8'h01);
    for (int i = 0; i < 257; i++) rf_byte(8'(i), i == 256);
    check(em_ovf, 1'b1);
    // Fill the receive ring past full, radio stalled
    rf_ready = 1'b0;
    for (int i = 0; i < 513; i++) i_host.send_byte(8'(i));
    repeat (4) @(negedge clk);
    check(rx_ovf, 1'b1);
    repeat (GAP_CYC + 20) @(negedge clk);
    check({tx_valid, tx_data}, 9'h100);
    mon_q.delete();
    rf_ready = 1'b1;
    repeat (2000) @(negedge clk);
    check(12'(mon_q.size()), 12'h200);
    check(mon_q[511], 12'h7FF);
    check(rx_ovf, 1'b0);
    check(em_ovf, 1'b0);
    check(24'(i_host.rx_q.size()), 24'h000100);
    close_out();
  end
endmodule : urbb_top_test
